/* rss_consts.vh */
// Constants of the reset strap sampler: strap bit positions, pull defaults,
// register map and timing. Included by the design files only.
`ifndef RSS_CONSTS_VH
`define RSS_CONSTS_VH
// Strap vector bit positions
`define RSS_BIT_BOOT 0
`define RSS_BIT_IRQ 1
`define RSS_BIT_LINK 2
`define RSS_BIT_LOCK 3
`define RSS_BIT_TMA 4
`define RSS_BIT_TMB 5
`define RSS_BIT_TMC 6
`define RSS_NSTRAP 7
// Default strap levels set by the internal pulls during reset
`define RSS_STRAP_DEFAULT 7'h70
// Pull-up select during reset (1 = pull-up, 0 = pull-down)
`define RSS_PULLUP_IN_RESET 7'h70
// Pull-up select after reset (boot select and bus hold pads only)
`define RSS_PULLUP_AFTER 7'h09
// Pads that are driven outputs after reset
`define RSS_DRIVEN_AFTER 7'h76
// Register map (byte addresses)
`define RSS_ADDR_STRAP 4'h0
`define RSS_ADDR_SYSCFG 4'h4
`define RSS_ADDR_SDRCFG 4'h8
`define RSS_ADDR_STATUS 4'hC
`define RSS_SYSCFG_RESET 32'h00000000
`define RSS_SDRCFG_RESET 32'h00000000
// Delay from reset release to pad function switch
`define RSS_SWITCH_NS 100
`define RSS_CLK_MHZ 40
`endif

/* rss_sync2.v */
// Two-flop synchroniser for a vector of pad levels.
// Assumes asynchronous pad inputs and one system clock with enable.
module rss_sync2 #(
    parameter W = 7,
    parameter [W-1:0] INIT = {W{1'b0}}
)
(
    // Clock and reset
    input wire clk_sys_i,
    input wire rst_i,
    input wire ce_i,
    // Data
    input wire [W-1:0] d_i,
    output reg [W-1:0] q_o
);
    reg [W-1:0] meta;

    always @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            meta <= INIT;
            q_o <= INIT;
        end
        else if (ce_i)
        begin
            meta <= d_i;
            q_o <= meta;
        end
    end
endmodule // rss_sync2

/* rss_sampler.v */
// Reset strap sampler: latches strap pad levels at reset release, switches
// pads to normal role, and exposes settings over a classic Wishbone slave.
// Assumes rst_i is the system reset (active high); rst_in_n_i is the pad-level
// active-low reset input, asynchronous to clk_sys_i.
`include "rss_consts.vh"

// Function
// - Capture every strap level at the rising edge of the active-low reset.
// - Shortly after reset release, return each strap pad to its normal role.
// - Each strap pad is shared: strap role in reset, normal signal afterwards.
// - Internal pulls set default levels, which are latched when undriven.
// - Boot strap 0 boots from external memory; 1 idles awaiting external load.
// - Interrupt strap 0 disables, level-sense; 1 enables, edge-sense four inputs.
// - Link width strap 0 gives 1-bit receive width; 1 gives 4-bit.
// - Lock strap 0 allows one write per config register; 1 always writable.
// - Pulls per default in reset; then boot/bus pads pull up, others drive.
// - Interrupt inputs stay disabled unless strap and vectors enable them.
module rss_sampler #(
    parameter SWITCH_CYCLES = (`RSS_SWITCH_NS * `RSS_CLK_MHZ + 999) / 1000
)
(
    // Clock, reset, enable
    input wire clk_sys_i,
    input wire rst_i,
    input wire ce_i,
    // Pad-level reset and strap pads
    input wire rst_in_n_i,
    input wire [6:0] strap_pad_i,
    // Pad control
    output wire [6:0] pad_pullup_en_o,
    output wire [6:0] pad_pulldown_en_o,
    output wire [6:0] pad_func_oe_o,
    output wire pad_normal_role_o,
    // Normal-role pad outputs from the core
    input wire [6:0] func_out_i,
    output wire [6:0] pad_out_o,
    // Latched settings
    output reg boot_source_strap_o,
    output reg irq_enable_strap_o,
    output reg link_rx_width_strap_o,
    output reg config_reg_lock_strap_o,
    output reg [2:0] test_mode_strap_o,
    output reg boot_from_memory_o,
    output reg boot_wait_external_o,
    output reg [3:0] irq_enable_o,
    output reg [3:0] irq_edge_sense_o,
    output reg [2:0] link_rx_width_o,
    input wire irq_vectors_ready_i,
    // Wishbone classic slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [3:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    output reg wb_err_o,
    // Configuration registers
    output reg [31:0] system_config_reg_o,
    output reg [31:0] sdram_config_reg_o
);
    localparam ST_RESET = 2'b00;
    localparam ST_HOLD = 2'b01;
    localparam ST_NORMAL = 2'b10;
    // Last count of the hold phase, cut to the counter width on purpose
    localparam [31:0] SWITCH_W = SWITCH_CYCLES;
    localparam [15:0] HOLD_LAST = SWITCH_W[15:0] - 16'h0001;

    reg [1:0] state;
    reg [15:0] hold_cnt;
    reg [6:0] latched;
    reg sys_written;
    reg sdr_written;
    wire [6:0] pad_sync;
    wire rst_sync;
    reg rst_pad_prev;

    // Pad levels and pad reset cross in through two flops
    rss_sync2 #(.W(7), .INIT(`RSS_STRAP_DEFAULT)) u_sync_pad (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .d_i(strap_pad_i),
        .q_o(pad_sync)
    );
    rss_sync2 #(.W(1), .INIT(1'b0)) u_sync_rst (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .d_i(rst_in_n_i),
        .q_o(rst_sync)
    );

    function [31:0] rss_merge;
        input [31:0] old;
        input [31:0] data;
        input [3:0] sel;
        integer i;
        begin
            rss_merge = old;
            for (i = 0; i < 4; i = i + 1)
                if (sel[i])
                    rss_merge[i*8 +: 8] = data[i*8 +: 8];
        end
    endfunction

    wire in_reset = (state == ST_RESET);
    wire rise = rst_sync & ~rst_pad_prev;

    // Pull selection follows reset phase
    assign pad_pullup_en_o = in_reset ? `RSS_PULLUP_IN_RESET : `RSS_PULLUP_AFTER;
    assign pad_pulldown_en_o = in_reset ? ~`RSS_PULLUP_IN_RESET : 7'h00;
    assign pad_func_oe_o = (state == ST_NORMAL) ? `RSS_DRIVEN_AFTER : 7'h00;
    assign pad_out_o = (state == ST_NORMAL) ? func_out_i : 7'h00;
    assign pad_normal_role_o = (state == ST_NORMAL);

    always @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state <= ST_RESET;
            hold_cnt <= 16'h0000;
            rst_pad_prev <= 1'b0;
            latched <= `RSS_STRAP_DEFAULT;
        end
        else if (ce_i)
        begin
            rst_pad_prev <= rst_sync;
            case (state)
                ST_RESET:
                begin
                    // Sample the pad value seen alongside the reset edge
                    if (rise)
                    begin
                        latched <= pad_sync;
                        hold_cnt <= 16'h0000;
                        state <= ST_HOLD;
                    end
                end
                ST_HOLD:
                begin
                    if (!rst_sync)
                        state <= ST_RESET;
                    else if (hold_cnt >= HOLD_LAST)
                        state <= ST_NORMAL;
                    else
                        hold_cnt <= hold_cnt + 16'h0001;
                end
                ST_NORMAL:
                begin
                    // Pad activity ignored; only a new pad reset re-arms
                    if (!rst_sync)
                        state <= ST_RESET;
                end
                default:
                    state <= ST_RESET;
            endcase
        end
    end

    // Decoded settings, registered from the latched straps
    always @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            boot_source_strap_o <= 1'b0;
            irq_enable_strap_o <= 1'b0;
            link_rx_width_strap_o <= 1'b0;
            config_reg_lock_strap_o <= 1'b0;
            test_mode_strap_o <= 3'h7;
            boot_from_memory_o <= 1'b0;
            boot_wait_external_o <= 1'b0;
            irq_enable_o <= 4'h0;
            irq_edge_sense_o <= 4'h0;
            link_rx_width_o <= 3'h1;
        end
        else if (ce_i)
        begin
            boot_source_strap_o <= latched[`RSS_BIT_BOOT];
            irq_enable_strap_o <= latched[`RSS_BIT_IRQ];
            link_rx_width_strap_o <= latched[`RSS_BIT_LINK];
            config_reg_lock_strap_o <= latched[`RSS_BIT_LOCK];
            test_mode_strap_o <= latched[`RSS_BIT_TMC:`RSS_BIT_TMA];
            boot_from_memory_o <= (state == ST_NORMAL) & ~latched[`RSS_BIT_BOOT];
            boot_wait_external_o <= (state == ST_NORMAL) & latched[`RSS_BIT_BOOT];
            irq_enable_o <= {4{(state == ST_NORMAL) & latched[`RSS_BIT_IRQ] & irq_vectors_ready_i}};
            irq_edge_sense_o <= {4{latched[`RSS_BIT_IRQ]}};
            link_rx_width_o <= latched[`RSS_BIT_LINK] ? 3'h4 : 3'h1;
        end
    end

    // Wishbone slave: ack (err if unmapped) one cycle after request, dropped the next cycle
    wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    wire hit_sys = (wb_adr_i == `RSS_ADDR_SYSCFG);
    wire hit_sdr = (wb_adr_i == `RSS_ADDR_SDRCFG);
    wire mapped = hit_sys | hit_sdr | (wb_adr_i == `RSS_ADDR_STRAP) | (wb_adr_i == `RSS_ADDR_STATUS);
    wire sys_open = latched[`RSS_BIT_LOCK] | ~sys_written;
    wire sdr_open = latched[`RSS_BIT_LOCK] | ~sdr_written;

    always @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            sys_written <= 1'b0;
            sdr_written <= 1'b0;
            system_config_reg_o <= `RSS_SYSCFG_RESET;
            sdram_config_reg_o <= `RSS_SDRCFG_RESET;
        end
        else if (ce_i)
        begin
            wb_ack_o <= req & mapped;
            wb_err_o <= req & ~mapped;
            if (req && wb_we_i && hit_sys && sys_open && (state == ST_NORMAL))
            begin
                system_config_reg_o <= rss_merge(system_config_reg_o, wb_dat_i, wb_sel_i);
                sys_written <= 1'b1;
            end
            if (req && wb_we_i && hit_sdr && sdr_open && (state == ST_NORMAL))
            begin
                sdram_config_reg_o <= rss_merge(sdram_config_reg_o, wb_dat_i, wb_sel_i);
                sdr_written <= 1'b1;
            end
            if (state == ST_RESET)
            begin
                sys_written <= 1'b0;
                sdr_written <= 1'b0;
            end
            if (req && !wb_we_i)
            begin
                case (wb_adr_i)
                    `RSS_ADDR_STRAP: wb_dat_o <= {25'h0, latched};
                    `RSS_ADDR_SYSCFG: wb_dat_o <= system_config_reg_o;
                    `RSS_ADDR_SDRCFG: wb_dat_o <= sdram_config_reg_o;
                    `RSS_ADDR_STATUS: wb_dat_o <= {28'h0000000, sdr_written, sys_written, state};
                    default: wb_dat_o <= 32'h00000000;
                endcase
            end
        end
    end
endmodule // rss_sampler

/* rss_strap_board.sv */
// Board-side model of the seven strap pads: straps, internal pulls, device drive.
// Assumes the pad controls come straight from rss_sampler.
module rss_strap_board
(
    // Clock
    input wire logic clk_sys_i,
    // Pad controls from the device
    input wire logic [6:0] pullup_en_i,
    input wire logic [6:0] pulldown_en_i,
    input wire logic [6:0] func_oe_i,
    input wire logic [6:0] func_out_i,
    // Board straps on pads 0 to 3, stronger than the pulls
    input wire logic [6:0] strap_en_i,
    input wire logic [6:0] strap_val_i,
    // Resolved pad levels
    output logic [6:0] pad_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [6:0] float_lvl = 7'h55;
    always @(posedge clk_sys_i)
        float_lvl <= ~float_lvl;
    // A pad nobody holds toggles, so a stale level is never read as valid
    always_comb
    begin
        for (int i = 0; i < 7; i++)
        begin
            if (func_oe_i[i])
                pad_o[i] = func_out_i[i];
            else if (strap_en_i[i] && i < 4)
                pad_o[i] = strap_val_i[i];
            else if (pullup_en_i[i] || pulldown_en_i[i])
                pad_o[i] = pullup_en_i[i];
            else
                pad_o[i] = float_lvl[i];
        end
    end
endmodule // rss_strap_board

/* rss_sampler_asserts.sv */
// Checker of the strap sampler pad and bus behaviour.
// Assumes ce_i held high, so pad-reset latencies stay fixed.
module rss_sampler_asserts #(
    parameter SWITCH_CYCLES = 4
)
(
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic rst_in_n_i,
    input wire logic [6:0] func_out_i,
    input wire logic [6:0] pad_pullup_en_o,
    input wire logic [6:0] pad_pulldown_en_o,
    input wire logic [6:0] pad_func_oe_o,
    input wire logic [6:0] pad_out_o,
    input wire logic pad_normal_role_o,
    input wire logic [2:0] test_mode_strap_o,
    input wire logic irq_enable_strap_o,
    input wire logic [3:0] irq_enable_o,
    input wire logic [3:0] irq_edge_sense_o,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic wb_err_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // Pad rise to normal role: two sync flops, edge detect, then the hold count
    localparam int ROLE_LAT = SWITCH_CYCLES + 3;
    // Held-off span written for the default hold count
    sequence role_held_off;
        (!pad_normal_role_o) [*7];
    endsequence
    sequence role_arrives;
        ##[ROLE_LAT:ROLE_LAT] pad_normal_role_o;
    endsequence
    sequence bus_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    endsequence
    pull_reset_a: assert property (!rst_in_n_i [*6] |-> pad_pullup_en_o == 7'h70 && pad_pulldown_en_o == 7'h0F)
        else $error("pulls wrong in reset");
    pull_after_a: assert property (pad_normal_role_o |-> pad_pullup_en_o == 7'h09 && pad_pulldown_en_o == 7'h00)
        else $error("pulls wrong after reset");
    pad_role_a: assert property (pad_normal_role_o |-> pad_func_oe_o == 7'h76 && pad_out_o == func_out_i)
        else $error("normal pad role wrong");
    pad_idle_a: assert property (!pad_normal_role_o |-> pad_func_oe_o == 7'h00 && pad_out_o == 7'h00)
        else $error("pad driven in reset");
    role_hold_a: assert property ($rose(rst_in_n_i) |-> role_held_off)
        else $error("pads left strap role too early");
    role_switch_a: assert property ($rose(rst_in_n_i) |-> role_arrives)
        else $error("role switch timing wrong");
    hold_straps_a: assert property (pad_normal_role_o && $past(pad_normal_role_o) |-> $stable({test_mode_strap_o, irq_enable_strap_o}))
        else $error("latched strap changed");
    irq_off_a: assert property (!irq_enable_strap_o [*2] |-> irq_enable_o == 4'h0 && irq_edge_sense_o == 4'h0)
        else $error("interrupts on without strap");
    bus_answer_a: assert property (bus_req |=> (wb_ack_o != wb_err_o) ##1 !wb_ack_o && !wb_err_o)
        else $error("bus answer wrong");
endmodule // rss_sampler_asserts

bind rss_sampler rss_sampler_asserts #(.SWITCH_CYCLES(SWITCH_CYCLES)) u_chk (.*);

/* rss_sampler_bench.sv */
// Self-checking bench of the strap sampler: default and overridden straps.
// Assumes the board model and checker files are compiled first.
`define CHK(nm, exp, got) begin total_checks++; if ((got) !== (exp)) begin error_cnt++; \
    $display("[ERR] %s exp %0h got %0h", nm, exp, got); end end
module rss_sampler_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i, rst_i, ce_i, rst_in_n_i, irq_vectors_ready_i, wb_cyc_i, wb_stb_i, wb_we_i, rerr;
    logic pad_normal_role_o, boot_source_strap_o, irq_enable_strap_o, link_rx_width_strap_o;
    logic config_reg_lock_strap_o, boot_from_memory_o, boot_wait_external_o, wb_ack_o, wb_err_o;
    logic [2:0] test_mode_strap_o, link_rx_width_o;
    logic [3:0] wb_adr_i, wb_sel_i, irq_enable_o, irq_edge_sense_o, cfg;
    logic [6:0] strap_pad_i, func_out_i, pad_pullup_en_o, pad_pulldown_en_o, pad_func_oe_o, pad_out_o;
    logic [6:0] strap_en, strap_val;
    logic [31:0] wb_dat_i, wb_dat_o, system_config_reg_o, sdram_config_reg_o, rdat, sdr_exp;
    int error_cnt = 0;
    int total_checks = 0;
    int n;
    rss_sampler dut (.*);
    rss_strap_board board (.clk_sys_i(clk_sys_i), .pullup_en_i(pad_pullup_en_o),
        .pulldown_en_i(pad_pulldown_en_o), .func_oe_i(pad_func_oe_o), .func_out_i(pad_out_o),
        .strap_en_i(strap_en), .strap_val_i(strap_val), .pad_o(strap_pad_i));
    initial
    begin
        clk_sys_i = 1'b0;
        forever #12.5 clk_sys_i = ~clk_sys_i;
    end
    always @(posedge clk_sys_i)
        if (rst_i)
            func_out_i <= 7'h00;
        else
            func_out_i <= func_out_i + 7'h01;
    task automatic tally_and_finish;
        if (error_cnt == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // Entered just after a rising edge; leaves one idle cycle behind it
    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
        int k;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        k = 0;
        do
        begin
            @(posedge clk_sys_i);
            k++;
        end
        while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && k < 20);
        if (k >= 20)
            error_cnt++;
        rdat = wb_dat_o;
        rerr = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    initial
    begin
        rst_i = 1'b1;
        ce_i = 1'b1;
        rst_in_n_i = 1'b0;
        irq_vectors_ready_i = 1'b0;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 4'h0;
        wb_sel_i = 4'hF;
        wb_dat_i = 32'h00000000;
        strap_en = 7'h00;
        strap_val = 7'h00;
        sdr_exp = 32'h00000000;
        repeat (6) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        for (int k = 0; k < 2; k++)
        begin
            cfg = k ? 4'hF : 4'h0;
            rst_in_n_i <= 1'b0;
            strap_en <= k ? 7'h0F : 7'h00;
            strap_val <= {3'h0, cfg};
            repeat (8) @(posedge clk_sys_i);
            `CHK("pull_up", 7'h70, pad_pullup_en_o)
            wb(1'b1, 4'h8, 32'hFFFF0000);
            rst_in_n_i <= 1'b1;
            n = 0;
            do
            begin
                @(posedge clk_sys_i);
                n++;
            end
            while (pad_normal_role_o !== 1'b1 && n < 30);
            // Two sync flops and edge detect, four hold cycles, one to see it
            `CHK("role_lat", 8, n)
            // Pads now move; the latched copy must not follow them
            strap_val <= {3'h0, ~cfg};
            irq_vectors_ready_i <= 1'b1;
            repeat (3) @(posedge clk_sys_i);
            `CHK("straps", {3'h7, cfg}, {test_mode_strap_o, config_reg_lock_strap_o, link_rx_width_strap_o, irq_enable_strap_o, boot_source_strap_o})
            `CHK("boot", {~cfg[0], cfg[0]}, {boot_from_memory_o, boot_wait_external_o})
            `CHK("irq", {2{cfg}}, {irq_enable_o, irq_edge_sense_o})
            `CHK("link_w", cfg[2] ? 3'h4 : 3'h1, link_rx_width_o)
            `CHK("drive", 7'h76, pad_func_oe_o)
            wb(1'b0, 4'h0, 32'h00000000);
            `CHK("vector", {25'h0, 3'h7, cfg}, rdat)
            wb(1'b0, 4'h8, 32'h00000000);
            `CHK("sdr_hold", sdr_exp, rdat)
            wb(1'b1, 4'h4, 32'hA5A50001);
            wb(1'b1, 4'h4, 32'h5A5A0002);
            wb(1'b0, 4'h4, 32'h00000000);
            `CHK("sys_cfg", k ? 32'h5A5A0002 : 32'hA5A50001, rdat)
            `CHK("sys_out", k ? 32'h5A5A0002 : 32'hA5A50001, system_config_reg_o)
            wb(1'b1, 4'h8, 32'h000000C3);
            // Lane 1 only: refused once locked, merged when always writable
            wb_sel_i <= 4'h2;
            wb(1'b1, 4'h8, 32'h0000AB00);
            wb_sel_i <= 4'hF;
            sdr_exp = k ? 32'h0000ABC3 : 32'h000000C3;
            `CHK("sdr_out", sdr_exp, sdram_config_reg_o)
            wb(1'b0, 4'h2, 32'h00000000);
            `CHK("unmapped", 1'b1, rerr)
            irq_vectors_ready_i <= 1'b0;
            repeat (2) @(posedge clk_sys_i);
            `CHK("irq_gate", 4'h0, irq_enable_o)
        end
        tally_and_finish();
    end
    initial
    begin
        repeat (3000) @(posedge clk_sys_i);
        error_cnt++;
        tally_and_finish();
    end
endmodule // rss_sampler_bench
